/* File: design/csm_regs.vh */
// Constants for the signal code mapper and output message transmitters
`ifndef CSM_REGS_VH
`define CSM_REGS_VH
// Field types
`define CSM_T_UNDEF 3'h0
`define CSM_T_BIT1 3'h1
`define CSM_T_BIT2 3'h2
`define CSM_T_BIT4 3'h3
`define CSM_T_BYTE1 3'h4
`define CSM_T_BYTE2 3'h5
`define CSM_T_BYTE4 3'h6
// Logical signal states
`define CSM_S_VALID 2'h0
`define CSM_S_SPECIAL 2'h1
`define CSM_S_ERROR 2'h2
`define CSM_S_NA 2'h3
// Code range limits: last valid (last special for 4-bit), special base, error base, not-available base
`define CSM_B4_LIM 32'h0000000d
`define CSM_B4_SPEC 32'h00000002
`define CSM_B4_ERR 32'h0000000e
`define CSM_B4_NA 32'h0000000f
`define CSM_C1_LIM 32'h000000fa
`define CSM_C1_SPEC 32'h000000fb
`define CSM_C1_ERR 32'h000000fe
`define CSM_C1_NA 32'h000000ff
`define CSM_C2_LIM 32'h0000faff
`define CSM_C2_SPEC 32'h0000fb00
`define CSM_C2_ERR 32'h0000fe00
`define CSM_C2_NA 32'h0000ff00
`define CSM_C4_LIM 32'hfaffffff
`define CSM_C4_SPEC 32'hfb000000
`define CSM_C4_ERR 32'hfe000000
`define CSM_C4_NA 32'hff000000
// Reset values and rate limit of the transmitter settings
`define CSM_RST_EN 1'h0
`define CSM_RST_RATE 14'h0064
`define CSM_MAX_RATE 14'h2710
`define CSM_RST_PGN 18'h0ff01
`define CSM_RST_TYPE1 `CSM_T_BYTE1
`define CSM_RST_SRC1 4'h1
`define CSM_RST_SPAN1 32'h000000fa
`define CSM_RST_SPAN 32'h00000001
`define CSM_RST_POS 4'h1
// Frame identifier
`define CSM_PRIO 3'h6
`define CSM_PDU2_PF 8'hf0
`define CSM_GLOBAL_DA 8'hff
// Rate tick: one millisecond at 125 MHz
`define CSM_CLK_KHZ 125000
`define CSM_TICK_MS 1
`define CSM_MS_CYC (`CSM_CLK_KHZ * `CSM_TICK_MS)
`endif

/* File: design/csm_tx_mapper.v */
// Signal code mapper, three output message transmitters and frame FIFO
// Summary of operation
// RQ1 - 2-bit field: 0,1 valid; 2 error; 3 not available, value and code zero
// RQ2 - 1-bit field: both codes valid, value is the bit, code zero
// RQ3 - 4-bit field: 0,1 valid; 2..13 special code-2; 14 error; 15 not available
// RQ4 - 1-byte: up to 250 valid; 251..253 special code-251; FE error; FF not available
// RQ5 - 2-byte: up to FAFF valid; FBxx..FDxx special; FExx error code; FFxx not available
// RQ6 - 4-byte: same ranges scaled to 32 bits with special and error codes from bases
// RQ7 - Non-valid decoded states give value zero; special and error codes count from their range base, not available gives code zero
// RQ8 - Encoding inverts decoding so state and code round-trip through any field; a state or code the field cannot hold encodes as all ones
// RQ9 - Three independent transmitters, each sending its own single-frame message
// RQ10 - Each transmitter packs up to five signals into eight data bytes
// RQ11 - No specific destination; PDU1 group numbers use the global address
// RQ12 - Nothing is sent unless enabled; enable is off after reset
// RQ13 - Rate 0..10000, default 100; nonzero is periodic, zero is on request only
// RQ14 - Group number per transmitter, default 65281
// RQ15 - Each signal selects a logical source or not connected; signal 1 is 1-byte (the code makes this only its reset type; CFG_TYPE can set any type)
// RQ16 - Per signal inversion of the logical value before encoding, default off
// RQ17 - Byte position 1..8; continuous values start with their low byte there
// RQ18 - Discrete fields use bit position 1..8 for their low bit in that byte
// RQ19 - Discrete fields are configured never to straddle two bytes
// RQ20 - Continuous values scaled by resolution, offset and min/max span
// RQ21 - Rate is a period in milliseconds counted from a clock-derived tick
// RQ22 - Not connected or undefined type sends the not-available code
`timescale 1ns/1ns
`include "csm_regs.vh"

module csm_fifo #(
  parameter W = 93,
  parameter D = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] cnt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt != D[AW:0]);
  assign out_valid = (cnt != {(AW+1){1'b0}});
  assign out_data = mem[rp];
  always @(posedge clk)
  begin
    if (rst)
    begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wp] <= in_data;
        wp <= (wp == D[AW-1:0] - 1'b1 || D[AW:0] == {1'b1, {AW{1'b0}}} && wp == {AW{1'b1}}) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop)
        rp <= (rp == D[AW-1:0] - 1'b1 || D[AW:0] == {1'b1, {AW{1'b0}}} && rp == {AW{1'b1}}) ? {AW{1'b0}} : rp + 1'b1;
      if (push && !pop)
        cnt <= cnt + 1'b1;
      else if (pop && !push)
        cnt <= cnt - 1'b1;
    end
  end
endmodule

module csm_tx_mapper #(
  parameter NSRC = 8,
  parameter MS_CYC = `CSM_MS_CYC
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Configuration, captured on CFG_LOAD except SA, which is used directly
  input wire CFG_LOAD,
  input wire [2:0] CFG_EN,
  input wire [41:0] CFG_RATE,
  input wire [53:0] CFG_PGN,
  input wire [44:0] CFG_TYPE,
  input wire [59:0] CFG_SRC,
  input wire [14:0] CFG_INV,
  input wire [59:0] CFG_BYTE,
  input wire [59:0] CFG_BIT,
  input wire [479:0] CFG_SPAN,
  input wire [479:0] CFG_OFS,
  input wire [7:0] SA,
  // Logical sources
  input wire [NSRC*2-1:0] SRC_STATE,
  input wire [NSRC*32-1:0] SRC_CODE,
  input wire [NSRC*16-1:0] SRC_VAL,
  // Send requests and status
  input wire [2:0] TX_REQ,
  output reg [2:0] TX_PEND,
  // Frame stream out
  output reg TX_VALID,
  input wire TX_READY,
  output reg [28:0] TX_ID,
  output reg [63:0] TX_DATA,
  // Field decoder
  input wire [2:0] DEC_TYPE,
  input wire [31:0] DEC_RAW,
  output reg [1:0] DEC_STATE,
  output reg [31:0] DEC_CODE,
  output reg [31:0] DEC_VALUE
);
  // Range limits {lim, spec, err, na} per field type
  function [127:0] lims;
    input [2:0] t;
    begin
      case (t)
        `CSM_T_BIT1: lims = {32'h1, 32'h2, 32'h2, 32'h2};
        `CSM_T_BIT2: lims = {32'h1, 32'h2, 32'h2, 32'h3};
        `CSM_T_BIT4: lims = {32'h1, `CSM_B4_SPEC, `CSM_B4_ERR, `CSM_B4_NA};
        `CSM_T_BYTE1: lims = {`CSM_C1_LIM, `CSM_C1_SPEC, `CSM_C1_ERR, `CSM_C1_NA};
        `CSM_T_BYTE2: lims = {`CSM_C2_LIM, `CSM_C2_SPEC, `CSM_C2_ERR, `CSM_C2_NA};
        `CSM_T_BYTE4: lims = {`CSM_C4_LIM, `CSM_C4_SPEC, `CSM_C4_ERR, `CSM_C4_NA};
        default: lims = 128'h0;
      endcase
    end
  endfunction

  function [31:0] wmask;
    input [2:0] t;
    begin
      case (t)
        `CSM_T_BIT1: wmask = 32'h1;
        `CSM_T_BIT2: wmask = 32'h3;
        `CSM_T_BIT4: wmask = 32'hf;
        `CSM_T_BYTE1: wmask = 32'hff;
        `CSM_T_BYTE2: wmask = 32'hffff;
        `CSM_T_BYTE4: wmask = 32'hffffffff;
        default: wmask = 32'h0;
      endcase
    end
  endfunction

  // Logical state to raw field value
  function [31:0] enc;
    input [2:0] t;
    input [1:0] st;
    input [31:0] cd;
    input [15:0] v;
    input [31:0] span;
    input [31:0] ofs;
    reg [127:0] l;
    reg [47:0] prod;
    reg [32:0] cnt;
    reg [31:0] nv;
    begin
      l = lims(t);
      prod = {32'h0, v} * {16'h0, span};
      cnt = {1'b0, ofs} + {1'b0, prod[47:16]};
      // All ones is the conventional not-available fill
      nv = wmask(t);
      case (st)
        `CSM_S_VALID:
          if (t <= `CSM_T_BIT4)
            enc = {31'h0, v != 16'h0};
          else
            enc = (cnt > {1'b0, l[127:96]}) ? l[127:96] : cnt[31:0]; // RQ20
        `CSM_S_SPECIAL:
          enc = (cd < l[63:32] - l[95:64]) ? l[95:64] + cd : nv; // RQ8
        `CSM_S_ERROR:
          enc = (cd < l[31:0] - l[63:32]) ? l[63:32] + cd : nv; // RQ8
        default:
          enc = nv;
      endcase
    end
  endfunction

  // Stored configuration
  reg [2:0] en;
  reg [41:0] rate;
  reg [53:0] pgn;
  reg [44:0] typ;
  reg [59:0] src;
  reg [14:0] inv;
  reg [59:0] bytep;
  reg [59:0] bitp;
  reg [479:0] span;
  reg [479:0] ofs;
  integer i;
  always @(posedge CLK)
  begin
    if (RST)
    begin
      en <= {3{`CSM_RST_EN}}; // RQ12
      rate <= {3{`CSM_RST_RATE}}; // RQ13
      pgn <= {3{`CSM_RST_PGN}}; // RQ14
      for (i = 0; i < 15; i = i + 1)
      begin
        typ[i*3 +: 3] <= (i % 5 == 0) ? `CSM_RST_TYPE1 : `CSM_T_UNDEF; // RQ15
        src[i*4 +: 4] <= (i % 5 == 0) ? `CSM_RST_SRC1 : 4'h0;
        span[i*32 +: 32] <= (i % 5 == 0) ? `CSM_RST_SPAN1 : `CSM_RST_SPAN;
        bytep[i*4 +: 4] <= `CSM_RST_POS;
        bitp[i*4 +: 4] <= `CSM_RST_POS;
      end
      inv <= 15'h0; // RQ16
      ofs <= 480'h0;
    end
    else if (CFG_LOAD)
    begin
      en <= CFG_EN;
      for (i = 0; i < 3; i = i + 1)
      begin
        rate[i*14 +: 14] <= (CFG_RATE[i*14 +: 14] > `CSM_MAX_RATE) ? `CSM_MAX_RATE : CFG_RATE[i*14 +: 14]; // RQ13
      end
      pgn <= CFG_PGN;
      typ <= CFG_TYPE;
      src <= CFG_SRC;
      inv <= CFG_INV;
      bytep <= CFG_BYTE;
      bitp <= CFG_BIT;
      span <= CFG_SPAN;
      ofs <= CFG_OFS;
    end
  end

  // Millisecond tick
  reg [16:0] div;
  reg tick;
  always @(posedge CLK)
  begin
    if (RST || div == MS_CYC[16:0] - 17'h1)
      div <= 17'h0;
    else
      div <= div + 17'h1;
    tick <= !RST && div == MS_CYC[16:0] - 17'h1; // RQ21
  end

  // Period counters and pending requests
  localparam ST_IDLE = 1'b0;
  localparam ST_BUILD = 1'b1;
  reg state;
  reg [1:0] sel;
  reg [41:0] per;
  reg [2:0] next_pend;
  reg [2:0] take;
  wire fifo_ready;
  always @*
  begin
    take = 3'h0;
    if (state == ST_IDLE && fifo_ready)
    begin
      if (TX_PEND[0])
        take = 3'h1;
      else if (TX_PEND[1])
        take = 3'h2;
      else if (TX_PEND[2])
        take = 3'h4;
    end
  end
  // Set wins: a request or expiry in the selecting cycle keeps the bit set
  integer n;
  always @*
  begin
    for (n = 0; n < 3; n = n + 1)
    begin
      next_pend[n] = TX_PEND[n] && !take[n];
      if (!en[n])
        next_pend[n] = 1'b0; // RQ12
      else if (TX_REQ[n]) // RQ13
        next_pend[n] = 1'b1;
      else if (tick && rate[n*14 +: 14] != 14'h0 && per[n*14 +: 14] >= rate[n*14 +: 14] - 14'h1)
        next_pend[n] = 1'b1; // RQ21
    end
  end
  integer p;
  always @(posedge CLK)
  begin
    if (RST)
    begin
      per <= 42'h0;
      TX_PEND <= 3'h0;
    end
    else
    begin
      for (p = 0; p < 3; p = p + 1)
      begin
        if (!en[p] || (tick && rate[p*14 +: 14] != 14'h0 && per[p*14 +: 14] >= rate[p*14 +: 14] - 14'h1))
          per[p*14 +: 14] <= 14'h0;
        else if (tick && rate[p*14 +: 14] != 14'h0)
          per[p*14 +: 14] <= per[p*14 +: 14] + 14'h1;
      end
      TX_PEND <= next_pend;
    end
  end

  always @(posedge CLK)
  begin
    if (RST)
    begin
      state <= ST_IDLE;
      sel <= 2'h0;
    end
    else
      case (state)
        ST_IDLE:
          if (take != 3'h0)
          begin
            sel <= take[0] ? 2'h0 : take[1] ? 2'h1 : 2'h2; // RQ9
            state <= ST_BUILD;
          end
        ST_BUILD:
          if (fifo_ready)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
  end

  // Frame assembly for the selected transmitter
  reg [63:0] data;
  reg [28:0] fid;
  reg [17:0] pg;
  reg [31:0] raw;
  reg [31:0] m;
  reg [6:0] sh;
  reg [3:0] bp;
  reg [3:0] bt;
  reg [3:0] s;
  reg [2:0] t;
  reg [1:0] st;
  reg [15:0] v;
  reg [31:0] cd;
  integer k;
  integer j;
  always @*
  begin
    data = {64{1'b1}};
    pg = pgn[sel*18 +: 18];
    for (j = 0; j < 5; j = j + 1) // RQ10
    begin
      k = sel * 5 + j;
      t = typ[k*3 +: 3];
      s = src[k*4 +: 4];
      bp = bytep[k*4 +: 4] - 4'h1;
      bt = bitp[k*4 +: 4] - 4'h1;
      st = `CSM_S_NA;
      v = 16'h0;
      cd = 32'h0;
      if (s != 4'h0 && s <= NSRC) // RQ15
      begin
        st = SRC_STATE[(s-1)*2 +: 2];
        v = SRC_VAL[(s-1)*16 +: 16];
        cd = SRC_CODE[(s-1)*32 +: 32];
      end
      if (inv[k])
        v = ~v; // RQ16
      raw = enc(t, st, cd, v, span[k*32 +: 32], ofs[k*32 +: 32]); // RQ22
      m = wmask(t);
      // Undefined types leave the bytes at fill; overflow past byte 8 is dropped
      sh = {bp[2:0], 3'h0} + ((t <= `CSM_T_BIT4) ? {4'h0, bt[2:0]} : 7'h0); // RQ17 RQ18
      data = (data & ~({32'h0, m} << sh)) | ({32'h0, raw & m} << sh);
    end
    // Destination field of a PDU1 group is the global address
    fid = {`CSM_PRIO, pg[17:8], (pg[15:8] < `CSM_PDU2_PF) ? `CSM_GLOBAL_DA : pg[7:0], SA}; // RQ11
  end

  wire fo_valid;
  wire [92:0] fo_data;
  wire fo_ready = !TX_VALID || TX_READY;
  csm_fifo #(.W(93), .D(4), .AW(2)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(state == ST_BUILD),
    .in_ready(fifo_ready),
    .in_data({fid, data}),
    .out_valid(fo_valid),
    .out_ready(fo_ready),
    .out_data(fo_data)
  );

  always @(posedge CLK)
  begin
    if (RST)
    begin
      TX_VALID <= 1'b0;
      TX_ID <= 29'h0;
      TX_DATA <= 64'h0;
    end
    else if (fo_ready)
    begin
      TX_VALID <= fo_valid;
      if (fo_valid)
      begin
        TX_ID <= fo_data[92:64];
        TX_DATA <= fo_data[63:0];
      end
    end
  end

  // Raw field decoder
  wire [127:0] dl = lims(DEC_TYPE);
  wire [31:0] dr = DEC_RAW & wmask(DEC_TYPE);
  always @(posedge CLK)
  begin
    if (RST)
    begin
      DEC_STATE <= `CSM_S_NA;
      DEC_CODE <= 32'h0;
      DEC_VALUE <= 32'h0;
    end
    else if (DEC_TYPE == `CSM_T_UNDEF || DEC_TYPE > `CSM_T_BYTE4)
    begin
      DEC_STATE <= `CSM_S_NA;
      DEC_CODE <= 32'h0;
      DEC_VALUE <= 32'h0;
    end
    else if (dr <= dl[127:96] || DEC_TYPE == `CSM_T_BIT1) // RQ2
    begin
      DEC_STATE <= `CSM_S_VALID;
      DEC_CODE <= 32'h0;
      DEC_VALUE <= dr;
    end
    else if (dr < dl[63:32]) // RQ3 RQ4 RQ5 RQ6
    begin
      DEC_STATE <= `CSM_S_SPECIAL;
      DEC_CODE <= dr - dl[95:64];
      DEC_VALUE <= 32'h0; // RQ7
    end
    else if (dr < dl[31:0]) // RQ1
    begin
      DEC_STATE <= `CSM_S_ERROR;
      DEC_CODE <= dr - dl[63:32];
      DEC_VALUE <= 32'h0;
    end
    else
    begin
      DEC_STATE <= `CSM_S_NA;
      DEC_CODE <= 32'h0;
      DEC_VALUE <= 32'h0; // RQ7
    end
  end
endmodule

/* File: dv/csm_can_node.sv */
// Far-side CAN node model taking frames from the transmit stream
`timescale 1ns/1ns
module csm_can_node (
  // Clock
  input wire logic clk,
  // Frame stream acceptance
  output logic ready,
  // 0 prompt, 1 random stalls, 2 refuses all
  input wire logic [1:0] mode
);
  initial ready = 1'b0;
  // Lost arbitration on the bus shows up as back-pressure
  always @(posedge clk)
    ready <= (mode == 2'h0) || (mode == 2'h1 && $urandom_range(1, 0) == 1);
endmodule

/* File: dv/csm_tx_mapper_monitor.sv */
// Concurrent checks on the decoder and frame stream ports
`timescale 1ns/1ns
`include "csm_regs.vh"
module csm_tx_mapper_monitor (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Frame stream
  input wire TX_VALID,
  input wire TX_READY,
  input wire [28:0] TX_ID,
  input wire [63:0] TX_DATA,
  // Field decoder
  input wire [2:0] DEC_TYPE,
  input wire [31:0] DEC_RAW,
  input wire [1:0] DEC_STATE,
  input wire [31:0] DEC_CODE,
  input wire [31:0] DEC_VALUE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence s_stall;
    TX_VALID && !TX_READY;
  endsequence
  sequence s_held;
    TX_VALID && $stable(TX_ID) && $stable(TX_DATA);
  endsequence
  a_frame_held: assert property (s_stall |=> s_held)
    else $error("frame changed while stalled");
  a_two_bit_err: assert property (DEC_TYPE == `CSM_T_BIT2 && DEC_RAW[1:0] == 2'h2 |=>
    DEC_STATE == `CSM_S_ERROR && DEC_CODE == 32'h0 && DEC_VALUE == 32'h0) else $error("2-bit error code wrong");
  a_one_bit_val: assert property (DEC_TYPE == `CSM_T_BIT1 |=> DEC_STATE == `CSM_S_VALID &&
    DEC_CODE == 32'h0 && DEC_VALUE == {31'h0, $past(DEC_RAW[0])}) else $error("1-bit decode wrong");
  a_nib_special: assert property (DEC_TYPE == `CSM_T_BIT4 && DEC_RAW[3:0] inside {[4'h2:4'hd]} |=>
    DEC_STATE == `CSM_S_SPECIAL && DEC_CODE == $past(DEC_RAW[3:0]) - 32'h2) else $error("4-bit special wrong");
  a_byte_spec: assert property (DEC_TYPE == `CSM_T_BYTE1 && DEC_RAW[7:0] inside {[8'hfb:8'hfd]} |=>
    DEC_STATE == `CSM_S_SPECIAL && DEC_CODE == $past(DEC_RAW[7:0]) - 32'hfb) else $error("1-byte special wrong");
  a_word_err: assert property (DEC_TYPE == `CSM_T_BYTE2 && DEC_RAW[15:8] == 8'hfe |=>
    DEC_STATE == `CSM_S_ERROR && DEC_CODE == {24'h0, $past(DEC_RAW[7:0])}) else $error("2-byte error wrong");
  a_long_na: assert property (DEC_TYPE == `CSM_T_BYTE4 && DEC_RAW[31:24] == 8'hff |=>
    DEC_STATE == `CSM_S_NA && DEC_CODE == 32'h0 && DEC_VALUE == 32'h0) else $error("4-byte not available wrong");
  a_state_zero: assert property (DEC_STATE != `CSM_S_VALID |-> DEC_VALUE == 32'h0)
    else $error("value not zero outside valid state");
  a_global_dest: assert property (TX_VALID && TX_ID[23:16] < 8'hf0 |-> TX_ID[15:8] == `CSM_GLOBAL_DA)
    else $error("destination not global");
  a_frame_prio: assert property (TX_VALID |-> TX_ID[28:26] == `CSM_PRIO)
    else $error("frame priority wrong");
endmodule
bind csm_tx_mapper csm_tx_mapper_monitor u_mon (.CLK(CLK), .RST(RST), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
  .TX_ID(TX_ID), .TX_DATA(TX_DATA), .DEC_TYPE(DEC_TYPE), .DEC_RAW(DEC_RAW), .DEC_STATE(DEC_STATE),
  .DEC_CODE(DEC_CODE), .DEC_VALUE(DEC_VALUE));

/* File: dv/csm_tx_mapper_tb_top.sv */
// Self-checking bench for the code mapper and output message transmitters
`timescale 1ns/1ns
`include "csm_regs.vh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module csm_tx_mapper_tb_top;
  logic CLK = 0, RST = 1, CFG_LOAD = 0, TX_VALID, TX_READY, dv = 0;
  logic [2:0] CFG_EN = 0, TX_REQ = 0, TX_PEND, DEC_TYPE = 0;
  logic [41:0] rate = 0;
  logic [53:0] pgn = 0;
  logic [44:0] typ = 0;
  logic [59:0] src = 0, byt = 0, bitp = 0;
  logic [14:0] inv = 0;
  logic [479:0] span = 0, ofs = 0;
  logic [15:0] sst = 16'h0026;
  logic [255:0] scd = {160'h0, 32'h0, 32'h5, 32'h1};
  logic [127:0] sval = {64'h0, 16'h8000, 48'h0};
  logic [1:0] mode = 0, DEC_STATE;
  logic [31:0] DEC_RAW = 0, DEC_CODE, DEC_VALUE;
  logic [28:0] TX_ID;
  logic [63:0] TX_DATA;
  logic [65:0] dq[$], dd;
  logic [92:0] fq[$], ff;
  logic [31:0] bnd[22] = '{32'h0, 32'h1, 32'h2, 32'hd, 32'he, 32'hf, 32'hfa, 32'hfb, 32'hfd, 32'hfe, 32'hff,
    32'hfaff, 32'hfb00, 32'hfdff, 32'hfe01, 32'hfeff, 32'hff00, 32'hfaffffff, 32'hfb000000, 32'hfe000001,
    32'hff000000, 32'hffffffff};
  int fail_count = 0, num_checks = 0;
  localparam logic [28:0] ID0 = {3'h6, 10'h0ff, 8'h01, 8'h2b};
  localparam logic [28:0] ID1 = {3'h6, 10'h0ef, 8'hff, 8'h2b};
  localparam logic [28:0] ID2 = {3'h6, 10'h0fe, 8'h10, 8'h2b};
  localparam logic [63:0] D0 = 64'h7dfffefffe01ff7f;
  localparam logic [63:0] D1 = 64'hfe000001ffffffff;

  always #4 CLK = ~CLK;

  // Short millisecond so periodic sends fit the run
  csm_tx_mapper #(.NSRC(8), .MS_CYC(10)) DUT (.CLK(CLK), .RST(RST), .CFG_LOAD(CFG_LOAD), .CFG_EN(CFG_EN),
    .CFG_RATE(rate), .CFG_PGN(pgn), .CFG_TYPE(typ), .CFG_SRC(src), .CFG_INV(inv), .CFG_BYTE(byt),
    .CFG_BIT(bitp), .CFG_SPAN(span), .CFG_OFS(ofs), .SA(8'h2b), .SRC_STATE(sst), .SRC_CODE(scd),
    .SRC_VAL(sval), .TX_REQ(TX_REQ), .TX_PEND(TX_PEND), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .TX_ID(TX_ID), .TX_DATA(TX_DATA), .DEC_TYPE(DEC_TYPE), .DEC_RAW(DEC_RAW), .DEC_STATE(DEC_STATE),
    .DEC_CODE(DEC_CODE), .DEC_VALUE(DEC_VALUE));
  csm_can_node NODE (.clk(CLK), .ready(TX_READY), .mode(mode));

  // Same ladder for all field types: valid, special, error, not available
  function automatic logic [65:0] dexp(logic [2:0] t, logic [31:0] r);
    logic [31:0] l, s, e, n;
    {l, s, e, n} = {32'h1, 32'h2, 32'h2, 32'h3};
    case (t)
      `CSM_T_BIT1: r = r & 32'h1;
      `CSM_T_BIT2: r = r & 32'h3;
      `CSM_T_BIT4: {r, e, n} = {r & 32'hf, 32'he, 32'hf};
      `CSM_T_BYTE1: {r, l, s, e, n} = {r & 32'hff, `CSM_C1_LIM, `CSM_C1_SPEC, `CSM_C1_ERR, `CSM_C1_NA};
      `CSM_T_BYTE2: {r, l, s, e, n} = {r & 32'hffff, `CSM_C2_LIM, `CSM_C2_SPEC, `CSM_C2_ERR, `CSM_C2_NA};
      `CSM_T_BYTE4: {l, s, e, n} = {`CSM_C4_LIM, `CSM_C4_SPEC, `CSM_C4_ERR, `CSM_C4_NA};
      default: r = n;
    endcase
    if (r <= l) return {`CSM_S_VALID, 32'h0, r};
    if (r < e) return {`CSM_S_SPECIAL, r - s, 32'h0};
    if (r < n) return {`CSM_S_ERROR, r - e, 32'h0};
    return {`CSM_S_NA, 64'h0};
  endfunction

  task automatic sg(int k, logic [2:0] t, logic [3:0] s, logic [3:0] by, logic [3:0] bi);
    {typ[k*3+:3], src[k*4+:4], byt[k*4+:4], bitp[k*4+:4]} = {t, s, by, bi};
  endtask
  task automatic wait_n(int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic load;
    @(negedge CLK) CFG_LOAD = 1;
    @(negedge CLK) CFG_LOAD = 0;
  endtask
  task automatic req(logic [2:0] r);
    @(negedge CLK) TX_REQ = r;
    @(negedge CLK) TX_REQ = 0;
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge CLK)
    if (dv)
    begin
      #1 dd = dq.pop_front();
      `CHK("decode", dd, {DEC_STATE, DEC_CODE, DEC_VALUE})
    end
  // Both sides settle by the falling edge; the transfer lands on the next rising one
  always @(negedge CLK)
    if (TX_VALID === 1'b1 && TX_READY === 1'b1)
    begin
      ff = fq.size() ? fq.pop_front() : 'x;
      `CHK("frame", ff, {TX_ID, TX_DATA})
    end

  // About eight hundred cycles of tests; five thousand leaves room
  initial
  begin
    repeat (5000) @(posedge CLK);
    fail_count++;
    wrap_up;
  end

  initial
  begin
    void'($urandom(32'h32a6));
    wait_n(16);
    RST = 0;
    `CHK("pend", 3'h0, TX_PEND)
    req(3'h7);
    wait_n(8);
    `CHK("pend", 3'h0, TX_PEND)
    for (int t = 0; t < 8; t++)
      for (int i = 0; i < 42; i++)
      begin
        @(negedge CLK);
        DEC_TYPE = t[2:0];
        DEC_RAW = (i < 22) ? bnd[i] : $urandom;
        dq.push_back(dexp(DEC_TYPE, DEC_RAW));
        dv = 1;
      end
    @(negedge CLK) dv = 0;
    sg(0, `CSM_T_BYTE2, 4'h1, 4'h3, 4'h1);
    sg(1, `CSM_T_BIT4, 4'h2, 4'h1, 4'h5);
    sg(2, `CSM_T_BYTE1, 4'h0, 4'h2, 4'h1);
    sg(3, `CSM_T_BIT2, 4'h3, 4'h6, 4'h1);
    sg(4, `CSM_T_BYTE1, 4'h4, 4'h8, 4'h1);
    sg(5, `CSM_T_BYTE4, 4'h1, 4'h5, 4'h1);
    span[4*32+:32] = 32'hfa;
    pgn = {18'h0fe10, 18'h0ef00, 18'h0ff01};
    CFG_EN = 3'h3;
    load;
    mode = 2'h1;
    fq.push_back({ID0, D0});
    fq.push_back({ID1, D1});
    req(3'h3);
    wait_n(20);
    mode = 2'h2;
    repeat (6)
    begin
      fq.push_back({ID0, D0});
      req(3'h1);
      wait_n(6);
    end
    `CHK("pend", 3'h1, TX_PEND)
    mode = 2'h0;
    wait_n(40);
    `CHK("pend", 3'h0, TX_PEND)
    `CHK("drain", 0, fq.size())
    mode = 2'h1;
    CFG_EN = 3'h4;
    rate[28+:14] = 14'h3;
    // Inverted half scale: 0x7fff times 250 keeps 0x7c
    sg(10, `CSM_T_BYTE1, 4'h4, 4'h1, 4'h1);
    span[10*32+:32] = 32'hfa;
    inv[10] = 1'b1;
    load;
    repeat (11) fq.push_back({ID2, 64'hffffffffffffff7c});
    wait_n(305);
    CFG_EN = 3'h0;
    load;
    wait_n(10);
    `CHK("period", 1'b1, fq.size() <= 2)
    wrap_up;
  end
endmodule
